// >>> verilog/hkswt_pkg.sv
package hkswt_pkg;
  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [6:0] ADDR_TEMP_CTRL = 7'h12;
  localparam logic [6:0] ADDR_TEMP_OFFS = 7'h13;
  localparam logic [6:0] ADDR_WAKE_EXP = 7'h14;
  localparam logic [6:0] ADDR_WAKE_MANT_HI = 7'h15;
  localparam logic [6:0] ADDR_WAKE_MANT_LO = 7'h16;
  localparam logic [6:0] ADDR_WAKE_CNT_HI = 7'h17;
  localparam logic [6:0] ADDR_WAKE_CNT_LO = 7'h18;
  localparam logic [6:0] ADDR_SUP_THRESH = 7'h1a;
  localparam logic [6:0] ADDR_SUP_LEVEL = 7'h1b;
  localparam logic [6:0] ADDR_CONV_CTRL = 7'h0f;
  localparam logic [6:0] ADDR_CONV_VALUE = 7'h11;
  localparam logic [6:0] ADDR_OPMODE = 7'h07;
  localparam logic [6:0] ADDR_IRQ_EN2 = 7'h06;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_TEMP_CTRL = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [4:0] RST_SUP_THRESH = 5'h14;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int TC_RANGE_LO = 6;
  localparam int TC_OFFS_EN = 5;
  localparam int TC_TRIM_EN = 4;
  localparam int CC_START = 7;
  localparam int CC_SEL_LO = 4;
  localparam int CC_REF_LO = 2;
  localparam int OM_SLOW_XTAL = 6;
  localparam int OM_SUP_EN = 6 - 1;
  localparam int OM_WAKE_EN = 4;
  localparam int OM_SLEEP = 0;
  localparam int IE_WAKE = 3;
  localparam int IE_SUP = 2;
  localparam int WE_EXP_LO = 2;
  localparam logic [2:0] SEL_TEMP = 3'h0;
  localparam logic [1:0] RANGE_ABS = 2'h2;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_US = 350;
  localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
  localparam int SUP_ON_US = 250;
  localparam int SUP_ON_CYC = SUP_ON_US * CLK_MHZ;
  localparam int SUP_PERIOD_S = 1;
  localparam int SLOW_HZ = 32768;
  localparam int SUP_PERIOD_TICKS = SUP_PERIOD_S * SLOW_HZ;
  localparam int WAKE_PRESCALE = 4;
  localparam int SUP_FILTER = 4;
endpackage : hkswt_pkg

// >>> verilog/hkswt_edge.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with rising-edge pulse
module hkswt_edge
  import hkswt_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // async reset, low
  input wire logic i_async, // pin from outside
  output logic o_level, // synchronised level
  output logic o_rise // one-cycle rise pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  // ------------------------------------------------------------------
  // synchroniser
  // ------------------------------------------------------------------
  // first flop feeds only the second
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign o_level = sync_reg;
  assign o_rise = sync_reg & ~last_reg;
endmodule : hkswt_edge
`default_nettype wire

// >>> verilog/hkswt_top.sv
// Behaviour
// RL1: temp sensor powered when converter selects it
// RL2: host sequence select, ref, range, offset, start
// RL3: two-bit range field picks scale
// RL4: offset enable adds offset to result
// RL5: trim enable shifts sensor by trim
// RL6: shift control clear gives absolute kelvin
// RL7: below threshold with enable asserts interrupt
// RL8: supply coded 1.7 V plus 50 mV steps
// RL9: monitor powered 250 us every second
// RL10: four consecutive low readings before interrupt
// RL11: monitor in sleep starts RC oscillator
// RL12: supply level readable, upper bits zero
// RL13: wake timer counts from sleep entry
// RL14: period is 4 times mantissa times 2^exp
// RL15: expiry with enable asserts interrupt pin
// RL16: enabled expiry starts the fast crystal
// RL17: disabled expiry pulses general pin only
// RL18: wake count readable in two bytes
// RL19: crystal select moves slow clock to pin
// RL20: converter start self-clears after 350 us
// RL21: wake count reloads after each expiry
`timescale 1ns/1ps
`default_nettype none
module hkswt_top
  import hkswt_pkg::*;
(
  input wire logic i_core_clk, // 200 MHz system clock
  input wire logic i_rst_b, // async reset, low
  input wire logic i_wr_stb, // register write strobe
  input wire logic i_rd_stb, // register read strobe
  input wire logic [6:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data, registered
  input wire logic i_rc_clk, // 32.768 kHz rc clock
  input wire logic i_xtal_clk, // 32 kHz crystal on general pin zero
  input wire logic [7:0] i_conv_raw, // eight_bit_converter raw result
  input wire logic [4:0] i_supply_raw, // supply_monitor 5-bit sample
  output logic o_temp_sensor_on, // sensor power
  output logic o_tshift_on, // temperature_shift_control_bit
  output logic [1:0] o_temp_range, // analog range select
  output logic [3:0] o_temp_trim, // analog trim, zero when off
  output logic o_conv_busy, // conversion running
  output logic o_supply_mon_on, // monitor and converter power
  output logic o_rc_osc_on, // rc oscillator enable
  output logic o_xtal_pin_mode, // general_pin_zero as crystal
  output logic o_fast_xtal_on, // 30 MHz crystal start
  output logic o_wake_gp_pulse, // expiry on general pin
  output logic o_interrupt_pin_low // interrupt, active low
);
  logic [7:0] temp_ctrl_reg;
  logic [7:0] temp_offs_reg;
  logic [7:0] wake_exp_reg;
  logic [15:0] wake_mant_reg;
  logic [4:0] sup_thresh_reg;
  logic [7:0] conv_ctrl_reg;
  logic [7:0] opmode_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] conv_value_reg;
  logic [4:0] sup_level_reg;
  logic [15:0] wake_cnt_reg;
  logic [17:0] wake_pre_reg;
  logic [31:0] conv_cnt_reg;
  logic [31:0] sup_on_cnt_reg;
  logic [15:0] sup_tick_reg;
  logic [2:0] sup_low_reg;
  logic sup_irq_reg;
  logic wake_irq_reg;
  logic fast_xtal_reg;
  logic gp_pulse_reg;
  logic sleep_last_reg;
  logic [7:0] rdata_next;
  logic slow_tick;
  logic rc_tick;
  logic xt_tick;
  logic sleep_now;
  logic wake_run;
  logic sup_en;
  logic [17:0] pre_limit;
  logic wake_expire;
  logic [3:0] wake_exp;
  // ------------------------------------------------------------------
  // slow clock sampling
  // ------------------------------------------------------------------
  hkswt_edge u_rc_edge (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_rc_clk),
    .o_level(),
    .o_rise(rc_tick)
  );
  hkswt_edge u_xt_edge (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_xtal_clk),
    .o_level(),
    .o_rise(xt_tick)
  );
  // crystal select swaps the slow tick source
  assign slow_tick = opmode_reg[OM_SLOW_XTAL] ? xt_tick : rc_tick; // [RL19]
  assign o_xtal_pin_mode = opmode_reg[OM_SLOW_XTAL]; // [RL19]
  assign sleep_now = opmode_reg[OM_SLEEP];
  assign sup_en = opmode_reg[OM_SUP_EN];
  assign wake_exp = wake_exp_reg[WE_EXP_LO +: 4];
  // ------------------------------------------------------------------
  // host writes
  // ------------------------------------------------------------------
  // conversion start self-clears; a new write wins over the clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_ctrl_reg <= RST_TEMP_CTRL;
      temp_offs_reg <= RST_ZERO;
      wake_exp_reg <= RST_ZERO;
      wake_mant_reg <= {RST_ZERO, RST_ZERO};
      sup_thresh_reg <= RST_SUP_THRESH;
      conv_ctrl_reg <= RST_ZERO;
      opmode_reg <= RST_ZERO;
      irq_en_reg <= RST_ZERO;
    end else begin
      if (conv_ctrl_reg[CC_START] && conv_cnt_reg == 32'(CONV_CYC - 1)) begin
        conv_ctrl_reg[CC_START] <= 1'b0; // [RL20]
      end
      if (i_wr_stb) begin
        unique case (i_addr)
          ADDR_TEMP_CTRL: temp_ctrl_reg <= i_wdata;
          ADDR_TEMP_OFFS: temp_offs_reg <= i_wdata;
          ADDR_WAKE_EXP: wake_exp_reg <= {2'h0, i_wdata[5:0]};
          ADDR_WAKE_MANT_HI: wake_mant_reg[15:8] <= i_wdata;
          ADDR_WAKE_MANT_LO: wake_mant_reg[7:0] <= i_wdata;
          ADDR_SUP_THRESH: sup_thresh_reg <= i_wdata[4:0];
          ADDR_CONV_CTRL: conv_ctrl_reg <= i_wdata;
          ADDR_OPMODE: opmode_reg <= i_wdata;
          ADDR_IRQ_EN2: irq_en_reg <= i_wdata;
          default: ;
        endcase
      end
    end
  end
  // ------------------------------------------------------------------
  // temperature sensor and converter
  // ------------------------------------------------------------------
  // sensor powers itself whenever the converter points at it
  assign o_temp_sensor_on = conv_ctrl_reg[CC_SEL_LO +: 3] == SEL_TEMP; // [RL1]
  assign o_temp_range = temp_ctrl_reg[TC_RANGE_LO +: 2]; // [RL3]
  assign o_temp_trim = temp_ctrl_reg[TC_TRIM_EN] ? temp_ctrl_reg[3:0] : 4'h0; // [RL5]
  // shift bit shares the offset-enable position; absolute only in range 10
  assign o_tshift_on = temp_ctrl_reg[TC_OFFS_EN] | (o_temp_range != RANGE_ABS); // [RL6]
  assign o_conv_busy = conv_ctrl_reg[CC_START];
  // conversion timer; result latched when it ends
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      conv_cnt_reg <= 32'h0;
      conv_value_reg <= 8'h00;
    end else if (conv_ctrl_reg[CC_START]) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h1;
      if (conv_cnt_reg == 32'(CONV_CYC - 1)) begin
        // offset is unsigned and wraps; negative trim is analog only
        conv_value_reg <= temp_ctrl_reg[TC_OFFS_EN] ?
          i_conv_raw + temp_offs_reg : i_conv_raw; // [RL4] [RL20]
      end
    end else begin
      conv_cnt_reg <= 32'h0;
    end
  end
  // ------------------------------------------------------------------
  // supply monitor
  // ------------------------------------------------------------------
  // rc runs in sleep whenever monitor or rc-timed wake needs it
  assign o_rc_osc_on = (sup_en && sleep_now) ||
    (wake_run && !opmode_reg[OM_SLOW_XTAL]); // [RL11]
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sup_tick_reg <= 16'h0;
      sup_on_cnt_reg <= 32'h0;
      o_supply_mon_on <= 1'b0;
    end else if (!sup_en) begin
      sup_tick_reg <= 16'h0;
      sup_on_cnt_reg <= 32'h0;
      o_supply_mon_on <= 1'b0;
    end else begin
      if (slow_tick) begin
        sup_tick_reg <= (sup_tick_reg == 16'(SUP_PERIOD_TICKS - 1)) ?
          16'h0 : sup_tick_reg + 16'h1;
      end
      // measurement window opens once a second
      if (slow_tick && sup_tick_reg == 16'h0) begin
        o_supply_mon_on <= 1'b1; // [RL9]
        sup_on_cnt_reg <= 32'h0;
      end else if (o_supply_mon_on) begin
        sup_on_cnt_reg <= sup_on_cnt_reg + 32'h1;
        if (sup_on_cnt_reg == 32'(SUP_ON_CYC - 1)) begin
          o_supply_mon_on <= 1'b0;
        end
      end
    end
  end
  // sample at end of window; filter four lows in a row
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sup_level_reg <= 5'h00;
      sup_low_reg <= 3'h0;
      sup_irq_reg <= 1'b0;
    end else if (!sup_en) begin
      sup_low_reg <= 3'h0;
      sup_irq_reg <= 1'b0;
    end else if (o_supply_mon_on && sup_on_cnt_reg == 32'(SUP_ON_CYC - 1)) begin
      sup_level_reg <= i_supply_raw; // [RL8]
      if (i_supply_raw < sup_thresh_reg) begin
        if (sup_low_reg != 3'(SUP_FILTER)) begin
          sup_low_reg <= sup_low_reg + 3'h1;
        end
        sup_irq_reg <= sup_low_reg >= 3'(SUP_FILTER - 1); // [RL10]
      end else begin
        sup_low_reg <= 3'h0;
        sup_irq_reg <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------------
  // wake timer
  // ------------------------------------------------------------------
  // prescale 4 * 2^exp slow ticks per mantissa count
  assign pre_limit = 18'(WAKE_PRESCALE) << wake_exp; // [RL14]
  assign wake_expire = wake_run && slow_tick &&
    wake_pre_reg == pre_limit - 18'h1 && wake_cnt_reg == wake_mant_reg - 16'h1;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_run <= 1'b0;
      wake_pre_reg <= 18'h0;
      wake_cnt_reg <= 16'h0;
      sleep_last_reg <= 1'b0;
    end else begin
      sleep_last_reg <= sleep_now;
      if (sleep_now && !sleep_last_reg && opmode_reg[OM_WAKE_EN]) begin
        wake_run <= 1'b1; // [RL13]
        wake_pre_reg <= 18'h0;
        wake_cnt_reg <= 16'h0;
      end else if (!opmode_reg[OM_WAKE_EN] || !sleep_now) begin
        wake_run <= 1'b0;
      end else if (wake_run && slow_tick) begin
        if (wake_pre_reg == pre_limit - 18'h1) begin
          wake_pre_reg <= 18'h0;
          // reload keeps wake events periodic
          wake_cnt_reg <= wake_expire ? 16'h0 : wake_cnt_reg + 16'h1; // [RL21]
        end else begin
          wake_pre_reg <= wake_pre_reg + 18'h1;
        end
      end
    end
  end
  // expiry: interrupt plus crystal, or general-pin pulse only
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_irq_reg <= 1'b0;
      fast_xtal_reg <= 1'b0;
      gp_pulse_reg <= 1'b0;
    end else begin
      gp_pulse_reg <= wake_expire && !irq_en_reg[IE_WAKE]; // [RL17]
      if (wake_expire && irq_en_reg[IE_WAKE]) begin
        wake_irq_reg <= 1'b1; // [RL15]
        fast_xtal_reg <= 1'b1; // [RL16]
      end else if (i_rd_stb && i_addr == ADDR_WAKE_CNT_HI) begin
        wake_irq_reg <= 1'b0;
      end
      // an enabled expiry in the same cycle wins over the drop
      if (!sleep_now && !wake_irq_reg && !(wake_expire && irq_en_reg[IE_WAKE])) begin
        fast_xtal_reg <= 1'b0;
      end
    end
  end
  assign o_fast_xtal_on = fast_xtal_reg | !sleep_now;
  assign o_wake_gp_pulse = gp_pulse_reg;
  // pin low while either enabled source is pending
  assign o_interrupt_pin_low = !((sup_irq_reg && irq_en_reg[IE_SUP]) ||
    wake_irq_reg); // [RL7] [RL15]
  // ------------------------------------------------------------------
  // host reads
  // ------------------------------------------------------------------
  always_comb begin
    unique case (i_addr)
      ADDR_TEMP_CTRL: rdata_next = temp_ctrl_reg;
      ADDR_TEMP_OFFS: rdata_next = temp_offs_reg;
      ADDR_WAKE_EXP: rdata_next = wake_exp_reg;
      ADDR_WAKE_MANT_HI: rdata_next = wake_mant_reg[15:8];
      ADDR_WAKE_MANT_LO: rdata_next = wake_mant_reg[7:0];
      ADDR_WAKE_CNT_HI: rdata_next = wake_cnt_reg[15:8]; // [RL18]
      ADDR_WAKE_CNT_LO: rdata_next = wake_cnt_reg[7:0]; // [RL18]
      ADDR_SUP_THRESH: rdata_next = {3'h0, sup_thresh_reg};
      ADDR_SUP_LEVEL: rdata_next = sup_en ? {3'h0, sup_level_reg} : 8'h00; // [RL12]
      ADDR_CONV_CTRL: rdata_next = conv_ctrl_reg;
      ADDR_CONV_VALUE: rdata_next = conv_value_reg; // [RL2]
      ADDR_OPMODE: rdata_next = opmode_reg;
      ADDR_IRQ_EN2: rdata_next = irq_en_reg;
      default: rdata_next = 8'h00;
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd_stb) begin
      o_rdata <= rdata_next;
    end
  end
endmodule : hkswt_top
`default_nettype wire

// >>> dv/hkswt_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the housekeeping block
// ----------------------------------------
module hkswt_top_sva
  import hkswt_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // async reset, low
  input wire logic i_wr_stb, // write strobe
  input wire logic i_rd_stb, // read strobe
  input wire logic [6:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_temp_sensor_on, // sensor power
  input wire logic o_tshift_on, // shift control
  input wire logic [1:0] o_temp_range, // range
  input wire logic [3:0] o_temp_trim, // trim
  input wire logic o_conv_busy, // conversion busy
  input wire logic o_xtal_pin_mode, // pin as crystal
  input wire logic o_wake_gp_pulse // expiry pulse
);
  int busy_cnt;
  // busy length counter; a repetition of 70000 would be far too slow to unroll
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) busy_cnt <= 0;
    else busy_cnt <= o_conv_busy ? busy_cnt + 1 : 0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_sensor_power: assert property (
    i_wr_stb && i_addr == ADDR_CONV_CTRL |=>
    o_temp_sensor_on == ($past(i_wdata[6:4]) == SEL_TEMP)) else $error("sensor power wrong");
  a_range_out: assert property (
    i_wr_stb && i_addr == ADDR_TEMP_CTRL |=> o_temp_range == $past(i_wdata[7:6]))
    else $error("range output wrong");
  a_trim_out: assert property (
    i_wr_stb && i_addr == ADDR_TEMP_CTRL |=>
    o_temp_trim == ($past(i_wdata[4]) ? $past(i_wdata[3:0]) : 4'h0)) else $error("trim wrong");
  a_shift_mode: assert property (
    i_wr_stb && i_addr == ADDR_TEMP_CTRL |=>
    o_tshift_on == ($past(i_wdata[5]) || $past(i_wdata[7:6]) != RANGE_ABS))
    else $error("shift control wrong");
  a_busy_start: assert property (
    i_wr_stb && i_addr == ADDR_CONV_CTRL && i_wdata[7] |=> o_conv_busy)
    else $error("conversion did not start");
  a_busy_length: assert property (
    $fell(o_conv_busy) |-> busy_cnt >= CONV_CYC - 2 && busy_cnt <= CONV_CYC + 2)
    else $error("conversion time wrong");
  a_pulse_single: assert property (
    o_wake_gp_pulse |=> !o_wake_gp_pulse) else $error("expiry pulse too long");
  a_pin_mode: assert property (
    i_wr_stb && i_addr == ADDR_OPMODE |=> o_xtal_pin_mode == $past(i_wdata[6]))
    else $error("crystal pin mode wrong");
  a_level_upper: assert property (
    i_rd_stb && i_addr == ADDR_SUP_LEVEL |=> o_rdata[7:5] == 3'h0)
    else $error("level upper bits set");
endmodule : hkswt_top_sva
`default_nettype wire

// >>> dv/hkswt_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// slow clocks, sensor and supply sources
// ----------------------------------------
module hkswt_analog_model (
  input wire logic i_sensor_on, // sensor powered
  input wire logic i_rc_run, // rc oscillator running
  input wire logic i_xtal_run, // slow crystal running
  input wire logic [7:0] i_temp_val, // sensor level
  input wire logic [4:0] i_supply_val, // supply sample
  output logic o_rc_clk, // rc clock
  output logic o_xtal_clk, // crystal clock
  output logic [7:0] o_conv_raw, // converter result
  output logic [4:0] o_supply_raw // supply result
);
  initial o_rc_clk = 1'b0;
  initial o_xtal_clk = 1'b0;
  // clocks stand still when stopped
  always #40 o_rc_clk = i_rc_run ? ~o_rc_clk : o_rc_clk;
  always #41 o_xtal_clk = i_xtal_run ? ~o_xtal_clk : o_xtal_clk;
  // unpowered sensor gives garbage, not the last level
  assign o_conv_raw = i_sensor_on ? i_temp_val : ~i_temp_val;
  assign o_supply_raw = i_supply_val;
endmodule : hkswt_analog_model
`default_nettype wire

// >>> dv/hkswt_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench for the housekeeping block
// ----------------------------------------
module hkswt_top_bench import hkswt_pkg::*;;
  logic i_core_clk = 1'b0;
  logic i_rst_b, i_wr_stb, i_rd_stb, rc_run, xtal_run, rc_clk, xtal_clk;
  logic sensor_on, tshift_on, conv_busy, sup_on, rc_on, pin_mode, fast_on, gp_pulse, irq_b;
  logic [6:0] i_addr;
  logic [7:0] i_wdata, o_rdata, temp_val, conv_raw;
  logic [4:0] supply_val, supply_raw;
  logic [1:0] range;
  logic [3:0] trim;
  int num_errors, n_checks, cyc, n;
  logic [6:0] ra [8] = '{7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h1a, 7'h1b, 7'h7f};
  logic [7:0] rv [8] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
  logic [7:0] wv [8] = '{8'h20, 8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h0b, 8'hff, 8'hff};
  hkswt_top uut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_rc_clk(rc_clk), .i_xtal_clk(xtal_clk), .i_conv_raw(conv_raw), .i_supply_raw(supply_raw),
    .o_temp_sensor_on(sensor_on), .o_tshift_on(tshift_on), .o_temp_range(range),
    .o_temp_trim(trim), .o_conv_busy(conv_busy), .o_supply_mon_on(sup_on), .o_rc_osc_on(rc_on),
    .o_xtal_pin_mode(pin_mode), .o_fast_xtal_on(fast_on), .o_wake_gp_pulse(gp_pulse),
    .o_interrupt_pin_low(irq_b));
  hkswt_analog_model u_model (.i_sensor_on(sensor_on), .i_rc_run(rc_run), .i_xtal_run(xtal_run),
    .i_temp_val(temp_val), .i_supply_val(supply_val), .o_rc_clk(rc_clk), .o_xtal_clk(xtal_clk),
    .o_conv_raw(conv_raw), .o_supply_raw(supply_raw));
  // 200 MHz core clock
  always #2.5 i_core_clk = ~i_core_clk;
  // hang guard, well above the conversion plus wake tests
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobes, driven at the falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_wr_stb = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_core_clk);
    i_wr_stb = 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    i_rd_stb = 1'b1;
    i_addr = a;
    @(negedge i_core_clk);
    i_rd_stb = 1'b0;
    chk(what, exp, o_rdata);
  endtask : rchk
  // cycles until the irq pin falls or the expiry pulse shows
  task automatic wait_ev(input logic use_pin);
    n = 0;
    while (n < 400 && (use_pin ? irq_b !== 1'b0 : gp_pulse !== 1'b1)) begin
      @(negedge i_core_clk);
      n++;
    end
  endtask : wait_ev
  // main sequence
  initial begin
    i_rst_b = 1'b0;
    {i_wr_stb, i_rd_stb, xtal_run, i_addr, i_wdata} = '0;
    rc_run = 1'b1;
    temp_val = 8'hf0;
    supply_val = 5'h09;
    {num_errors, n_checks, cyc} = '0;
    repeat (2) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    chk("irq after reset", 8'h01, {7'h0, irq_b});
    chk("shift after reset", 8'h01, {7'h0, tshift_on});
    foreach (ra[i]) rchk("reset value", ra[i], rv[i]);
    foreach (ra[i]) wr(ra[i], wv[i]);
    foreach (ra[i]) rchk("readback", ra[i], i < 6 ? wv[i] : 8'h00);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_TEMP_CTRL, {r[1:0], 1'b0, r[0], 4'h9});
      chk("range", {6'h0, r[1:0]}, {6'h0, range});
      chk("shift", {7'h0, r != 2}, {7'h0, tshift_on});
      chk("trim", r[0] ? 8'h09 : 8'h00, {4'h0, trim});
    end
    // first supply window runs alongside the conversion, sample below threshold
    wr(ADDR_OPMODE, 8'h20);
    wr(ADDR_IRQ_EN2, 8'h04);
    wr(ADDR_CONV_CTRL, 8'h10);
    chk("sensor off", 8'h00, {7'h0, sensor_on});
    wr(ADDR_TEMP_OFFS, 8'h25);
    wr(ADDR_CONV_CTRL, 8'h00);
    chk("sensor on", 8'h01, {7'h0, sensor_on});
    wr(ADDR_TEMP_CTRL, 8'h20);
    wr(ADDR_CONV_CTRL, 8'h80);
    chk("busy", 8'h01, {7'h0, conv_busy});
    n = 0;
    while (n < 71000 && conv_busy !== 1'b0) begin
      @(negedge i_core_clk);
      n++;
      if (n == 100) chk("monitor on", 8'h01, {7'h0, sup_on});
    end
    chk("conversion time", 8'h01, {7'h0, n >= 69990 && n <= 70010});
    chk("monitor off", 8'h00, {7'h0, sup_on});
    chk("one low reading", 8'h01, {7'h0, irq_b});
    rchk("supply level", ADDR_SUP_LEVEL, 8'h09);
    rchk("start bit", ADDR_CONV_CTRL, 8'h00);
    rchk("temp value", ADDR_CONV_VALUE, 8'h15);
    $display("test temperature done");
    wr(ADDR_OPMODE, 8'h21);
    chk("rc osc", 8'h01, {7'h0, rc_on});
    wr(ADDR_WAKE_EXP, 8'h00);
    wr(ADDR_WAKE_MANT_HI, 8'h00);
    wr(ADDR_WAKE_MANT_LO, 8'h03);
    wr(ADDR_OPMODE, 8'h10);
    wr(ADDR_OPMODE, 8'h11);
    chk("fast xtal asleep", 8'h00, {7'h0, fast_on});
    wait_ev(1'b0);
    chk("wake period", 8'h01, {7'h0, n >= 160 && n <= 230});
    chk("no state change", 8'h00, {7'h0, fast_on});
    chk("irq quiet", 8'h01, {7'h0, irq_b});
    @(negedge i_core_clk);
    wait_ev(1'b0);
    chk("reload period", 8'h01, {7'h0, n >= 188 && n <= 196});
    rchk("count high", ADDR_WAKE_CNT_HI, 8'h00);
    rchk("count low", ADDR_WAKE_CNT_LO, 8'h00);
    wr(ADDR_IRQ_EN2, 8'h08);
    wr(ADDR_OPMODE, 8'h10);
    wr(ADDR_OPMODE, 8'h11);
    wait_ev(1'b1);
    chk("irq period", 8'h01, {7'h0, n >= 160 && n <= 230});
    chk("fast xtal", 8'h01, {7'h0, fast_on});
    rchk("count high", ADDR_WAKE_CNT_HI, 8'h00);
    chk("irq cleared", 8'h01, {7'h0, irq_b});
    $display("test wake timer done");
    wr(ADDR_IRQ_EN2, 8'h00);
    wr(ADDR_OPMODE, 8'h50);
    rc_run = 1'b0;
    xtal_run = 1'b1;
    wr(ADDR_OPMODE, 8'h51);
    chk("pin mode", 8'h01, {7'h0, pin_mode});
    wait_ev(1'b0);
    chk("crystal period", 8'h01, {7'h0, n >= 160 && n <= 240});
    $display("test crystal done");
    report_and_stop();
  end
endmodule : hkswt_top_bench
bind hkswt_top hkswt_top_sva u_sva (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_temp_sensor_on(o_temp_sensor_on), .o_tshift_on(o_tshift_on),
  .o_temp_range(o_temp_range), .o_temp_trim(o_temp_trim), .o_conv_busy(o_conv_busy),
  .o_xtal_pin_mode(o_xtal_pin_mode), .o_wake_gp_pulse(o_wake_gp_pulse));
`default_nettype wire
